// ===== logic/asrp_port.sv
// Serial result port of a dual simultaneous-sampling converter, with APB registers
//
// Local design decisions: the register addresses and the APB register port.
module asrp_port #(
    parameter int unsigned DIV_W = 8
) (
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    input  wire logic                     serial_parallel_select,
    input  wire logic                     clock_source_select,
    input  wire logic                     clock_edge_invert,
    input  wire logic                     frame_sync_invert,
    input  wire logic                     read_mode_or_chain_in,
    input  wire logic                     chan_order_sel,
    input  wire logic                     cs_n,
    input  wire logic                     rd_n,
    input  wire logic                     sclk_pin_i,
    input  wire logic                     conv_start,
    input  wire logic                     conv_done,
    input  wire logic [15:0]              result_a,
    input  wire logic [15:0]              result_b,
    output logic                          busy,
    output logic [15:8]                   data_pin_o,
    output logic [15:8]                   data_pin_oe,
    output logic                          irq,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr
);
    asrp_pkg::asrp_pins_s pin_raw;
    asrp_pkg::asrp_pins_s pin_s1_r;
    asrp_pkg::asrp_pins_s pin_s2_r;
    logic                 sclk_d_r;
    asrp_pkg::asrp_state_e state_r;
    logic [31:0]          shift_r;
    logic [31:0]          hold_r;
    logic                 hold_pend_r;
    logic                 data_ready_r;
    logic [asrp_pkg::CNT_W-1:0] bit_r;
    logic [1:0]           phase_r;
    logic [DIV_W-1:0]     div_cnt_r;
    logic [DIV_W-1:0]     div_r;
    logic                 tick;
    logic                 bus_en;
    logic                 ext_edge;
    logic                 ext_shift;
    logic                 read_err;
    logic                 frame_end;
    logic                 latch_now;
    logic                 int_start;
    logic [31:0]          ordered;
    logic [asrp_pkg::EV_W-1:0] status_r;
    logic [asrp_pkg::EV_W-1:0] irq_en_r;
    logic [asrp_pkg::EV_W-1:0] ev;
    logic [asrp_pkg::EV_W-1:0] clr;
    logic                 rd_err_r;
    logic [15:8]          pin_nxt;
    logic [15:8]          oe_nxt;
    logic                 sclk_int;
    logic                 sync_act;
    logic                 apb_wr;
    logic                 apb_rd;
    logic                 mapped;

    assign pin_raw = '{sps: serial_parallel_select, cso: clock_source_select,
                       inv_clk: clock_edge_invert, inv_sync: frame_sync_invert,
                       rmc: read_mode_or_chain_in, ab: chan_order_sel,
                       cs_n: cs_n, rd_n: rd_n, sclk: sclk_pin_i};

    // Two-flop synchroniser for every pin input
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // Same level as the synchroniser reset, so no false edge
            sclk_d_r <= 1'b1;
        end else begin
            sclk_d_r <= pin_s2_r.sclk;
        end
    end

    assign bus_en = !pin_s2_r.cs_n && !pin_s2_r.rd_n;
    // Chip select gates the host clock; invert picks the update edge
    assign ext_edge = !pin_s2_r.cs_n && (pin_s2_r.sclk != sclk_d_r)
                      && (pin_s2_r.sclk == !pin_s2_r.inv_clk);

    // Channel order picks which result goes first
    assign ordered = pin_s2_r.ab ? {result_b, result_a} : {result_a, result_b};

    // Internal serial clock rate divider
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_r <= '0;
        end else if (tick || state_r != asrp_pkg::ASRP_INT_SHIFT) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end
    assign tick = (state_r == asrp_pkg::ASRP_INT_SHIFT) && (div_cnt_r >= div_r);

    // Read mode high allows reading the old result while busy
    assign int_start = (state_r == asrp_pkg::ASRP_IDLE) && pin_s2_r.sps && !pin_s2_r.cso
                       && bus_en && data_ready_r && (pin_s2_r.rmc || !busy);
    assign frame_end = (state_r == asrp_pkg::ASRP_INT_SHIFT) && tick && phase_r == 2'd3
                       && bit_r == 6'(asrp_pkg::FRAME_BITS - 1);
    assign read_err  = conv_done && state_r == asrp_pkg::ASRP_EXT_SHIFT;
    // Host samples half a period after its update edge; the sync delay eats
    // most of that, so the pin shows the next bit as the register shifts
    assign ext_shift = pin_s2_r.sps && pin_s2_r.cso && ext_edge && !read_err
                       && (state_r == asrp_pkg::ASRP_EXT_SHIFT || (state_r == asrp_pkg::ASRP_IDLE && bus_en));
    // New results wait while an internal frame is still going out
    assign latch_now = (conv_done || hold_pend_r) && state_r != asrp_pkg::ASRP_INT_SHIFT;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_r      <= '0;
            hold_pend_r <= 1'b0;
        end else if (conv_done) begin
            hold_r      <= ordered;
            hold_pend_r <= !latch_now;
        end else if (latch_now) begin
            hold_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
        end else if (conv_start) begin
            busy <= 1'b1;
        end else if (latch_now) begin
            busy <= 1'b0;
        end
    end

    // Frame sequencer and the 32-bit shift register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r      <= asrp_pkg::ASRP_IDLE;
            shift_r      <= '0;
            bit_r        <= '0;
            phase_r      <= 2'd0;
            data_ready_r <= 1'b0;
        end else begin
            case (state_r)
                asrp_pkg::ASRP_IDLE: begin
                    bit_r   <= '0;
                    phase_r <= 2'd0;
                    if (int_start) begin
                        state_r      <= asrp_pkg::ASRP_INT_SHIFT;
                        data_ready_r <= 1'b0;
                    end else if (pin_s2_r.sps && pin_s2_r.cso && ext_edge && bus_en) begin
                        state_r      <= asrp_pkg::ASRP_EXT_SHIFT;
                        shift_r      <= {shift_r[30:0], pin_s2_r.rmc};
                        bit_r        <= 6'd1;
                        data_ready_r <= 1'b0;
                    end
                end
                asrp_pkg::ASRP_INT_SHIFT: begin
                    if (tick) begin
                        phase_r <= phase_r + 2'd1;
                        if (phase_r == 2'd3) begin
                            // Shift while the clock is low, mid-way between edges
                            if (frame_end) begin
                                state_r <= asrp_pkg::ASRP_IDLE;
                            end else begin
                                shift_r <= {shift_r[30:0], 1'b0};
                                bit_r   <= bit_r + 6'd1;
                            end
                        end
                    end
                end
                asrp_pkg::ASRP_EXT_SHIFT: begin
                    if (read_err || !pin_s2_r.cso || !pin_s2_r.sps) begin
                        state_r <= asrp_pkg::ASRP_IDLE;
                    end else if (ext_edge) begin
                        shift_r <= {shift_r[30:0], pin_s2_r.rmc};
                        bit_r   <= bit_r + 6'd1;
                        if (bit_r == 6'(asrp_pkg::FRAME_BITS - 1)) begin
                            state_r <= asrp_pkg::ASRP_IDLE;
                        end
                    end
                end
                default: state_r <= asrp_pkg::ASRP_IDLE;
            endcase
            if (latch_now) begin
                shift_r      <= conv_done ? ordered : hold_r;
                data_ready_r <= 1'b1;
            end
        end
    end

    assign sclk_int = (state_r == asrp_pkg::ASRP_INT_SHIFT) && (phase_r == 2'd1 || phase_r == 2'd2);
    // Frame drops out for one quarter bit at the start of the second channel
    assign sync_act = (state_r == asrp_pkg::ASRP_INT_SHIFT)
                      && !(bit_r == 6'(asrp_pkg::RES_W) && phase_r == 2'd0);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_err_r <= 1'b0;
        end else begin
            rd_err_r <= read_err && pin_s2_r.sps;
        end
    end

    // Shared pin roles
    always_comb begin
        pin_nxt = shift_r[31:24];
        oe_nxt  = {8{bus_en}};
        if (!pin_s2_r.sps) begin
            pin_nxt = ordered[31:24];
        end else begin
            pin_nxt[8]  = ext_shift ? shift_r[30] : shift_r[31];
            pin_nxt[9]  = sclk_int;
            oe_nxt[9]   = bus_en && !pin_s2_r.cso;
            pin_nxt[10] = sync_act ^ pin_s2_r.inv_sync;
            oe_nxt[10]  = bus_en && !pin_s2_r.cso;
            pin_nxt[11] = rd_err_r;
            oe_nxt[11]  = bus_en && pin_s2_r.cso;
            oe_nxt[15:12] = 4'h0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_pin_o  <= '0;
            data_pin_oe <= '0;
        end else begin
            data_pin_o  <= pin_nxt;
            data_pin_oe <= oe_nxt;
        end
    end

    // APB slave, one wait state
    assign apb_wr = psel && penable && !pready && pwrite;
    assign apb_rd = psel && penable && !pready && !pwrite;
    assign mapped = paddr inside {asrp_pkg::OFS_CTRL, asrp_pkg::OFS_STATUS, asrp_pkg::OFS_STATE,
                                  asrp_pkg::OFS_IRQ_EN, asrp_pkg::OFS_IRQ_CLR};

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= '0;
            if (apb_rd) begin
                case (paddr)
                    asrp_pkg::OFS_CTRL:   prdata <= 32'(div_r);
                    asrp_pkg::OFS_STATUS: prdata <= 32'(status_r);
                    asrp_pkg::OFS_STATE:  prdata <= {20'h0, bit_r, state_r, data_ready_r, busy, hold_pend_r,
                                                     pin_s2_r.sps};
                    asrp_pkg::OFS_IRQ_EN: prdata <= 32'(irq_en_r);
                    default:              prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_r    <= DIV_W'(asrp_pkg::DIV_RST);
            irq_en_r <= asrp_pkg::IRQ_EN_RST;
        end else if (apb_wr && paddr == asrp_pkg::OFS_CTRL) begin
            div_r <= pwdata[DIV_W-1:0];
        end else if (apb_wr && paddr == asrp_pkg::OFS_IRQ_EN) begin
            irq_en_r <= pwdata[asrp_pkg::EV_W-1:0];
        end
    end

    // Sticky events; a set in the clear cycle survives
    always_comb begin
        ev = '0;
        ev[asrp_pkg::EV_RD_ERR] = read_err;
        ev[asrp_pkg::EV_FRAME]  = frame_end;
        ev[asrp_pkg::EV_LATCH]  = latch_now;
        clr = (apb_wr && paddr == asrp_pkg::OFS_IRQ_CLR) ? pwdata[asrp_pkg::EV_W-1:0] : '0;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= '0;
            irq      <= 1'b0;
        end else begin
            status_r <= (status_r & ~clr) | ev;
            irq      <= |(((status_r & ~clr) | ev) & irq_en_r);
        end
    end
endmodule

// ===== logic/asrp_pkg.sv
// Package of constants and carrier types for the serial result port
// Operation
// - With serial/parallel select low the shared pins carry parallel result bits 8 to 11, else serial roles.
// - Both results sit in one 32-bit shift register that leaves the serial data pin MSB first.
// - The channel order select input decides which result leaves first.
// - With internal clock the serial data is steady across both serial clock edges.
// - External clock, no invert: data changes on the rising edge, host samples on the next falling edge.
// - External clock, inverted: data changes on the falling edge, host samples on the next rising edge.
// - The serial clock pin is driven by the device in internal mode and taken from the host in external mode.
// - Frame sync is produced only in internal clock mode.
// - Frame sync not inverted: high through the frame, pulsed low once after the first channel.
// - Frame sync inverted: low through the frame, pulsed high once after the first channel.
// - External mode: a read unfinished when the next conversion ends is dropped and the error flag pulses.
// - In serial mode parallel bits 12 to 15 are released to high impedance.
// - Internal mode: read mode high lets the old result go out during conversion, low waits for the end.
// - External mode: the chain input reappears on serial data 32 clock periods after the read starts.
// - Output pins are enabled only with chip select and read both low; chip select gates the external clock.
// - Busy rises at conversion start and falls once the results are latched into the shift register.
package asrp_pkg;
    localparam int unsigned RES_W       = 16;
    localparam int unsigned FRAME_BITS  = 32;
    localparam int unsigned CNT_W       = 6;
    localparam logic [7:0]  DIV_RST     = 8'h04;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_STATE   = 8'h08;
    localparam logic [7:0]  OFS_IRQ_EN  = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_CLR = 8'h10;

    // Event bit positions, shared by status, enable and clear
    localparam int unsigned EV_RD_ERR   = 0;
    localparam int unsigned EV_FRAME    = 1;
    localparam int unsigned EV_LATCH    = 2;
    localparam int unsigned EV_W        = 3;
    localparam logic [EV_W-1:0] IRQ_EN_RST = 3'h0;

    typedef enum logic [1:0] {
        ASRP_IDLE,
        ASRP_INT_SHIFT,
        ASRP_EXT_SHIFT
    } asrp_state_e;

    // Pin levels from outside the core clock domain
    typedef struct packed {
        logic sps;
        logic cso;
        logic inv_clk;
        logic inv_sync;
        logic rmc;
        logic ab;
        logic cs_n;
        logic rd_n;
        logic sclk;
    } asrp_pins_s;
endpackage

// ===== verif/asrp_port_monitor.sv
// Pin-level checks on the serial result port
module asrp_port_monitor (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic        serial_parallel_select,
    input wire logic        clock_source_select,
    input wire logic        cs_n,
    input wire logic        rd_n,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic        busy,
    input wire logic [15:8] data_pin_o,
    input wire logic [15:8] data_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mon_cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Four cycles covers the two-stage synchroniser plus the pin register
    sequence ser_held; serial_parallel_select [*4]; endsequence
    sequence par_rd_held; (!serial_parallel_select && !cs_n && !rd_n) [*4]; endsequence
    sequence off_held; (cs_n || rd_n) [*4]; endsequence
    sequence ext_held; (serial_parallel_select && clock_source_select) [*4]; endsequence
    sequence int_held; (serial_parallel_select && !clock_source_select) [*4]; endsequence

    upper_hiz_a: assert property (ser_held |-> data_pin_oe[15:12] == 4'h0)
        else $error("upper data pins driven in serial mode");
    par_drive_a: assert property (par_rd_held |-> data_pin_oe == 8'hff)
        else $error("parallel pins not driven during read");
    bus_gate_a: assert property (off_held |-> !data_pin_oe[8])
        else $error("data pin driven without select and read");
    ext_clk_in_a: assert property (ext_held |-> !data_pin_oe[9] && !data_pin_oe[10])
        else $error("clock or frame sync driven in external mode");
    int_no_err_a: assert property (int_held |-> !data_pin_oe[11])
        else $error("error pin driven in internal mode");
    err_pulse_a: assert property (ext_held ##0 $rose(data_pin_o[11]) |=> !data_pin_o[11])
        else $error("read error pulse longer than one cycle");
    busy_rise_a: assert property (conv_start |=> busy)
        else $error("busy did not rise after conversion start");
    busy_fall_a: assert property ((clock_source_select [*4]) ##0 conv_done |=> !busy)
        else $error("busy did not fall after results latched");
    int_data_steady_a: assert property (int_held ##0 (data_pin_oe[9] && $changed(data_pin_o[9]))
        |-> $stable(data_pin_o[8]))
        else $error("serial data moved on an internal clock edge");
endmodule

bind asrp_port asrp_port_monitor u_mon (.core_clk(core_clk), .arst_n(arst_n),
    .serial_parallel_select(serial_parallel_select), .clock_source_select(clock_source_select),
    .cs_n(cs_n), .rd_n(rd_n), .conv_start(conv_start), .conv_done(conv_done), .busy(busy),
    .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe));

// ===== verif/asrp_host_model.sv
// Host that reads the result port as clock master or as slave
module asrp_host_model (
    input wire logic       core_clk,
    input wire logic       start,
    input wire logic       ext_mode,
    input wire logic       inv_clk,
    input wire logic       inv_sync,
    input wire logic [5:0] edges,
    input wire logic       sd_i,
    input wire logic       sd_oe,
    input wire logic       line_clk,
    input wire logic       fsync,
    output logic           sclk,
    output logic [32:0]    word,
    output logic           sync_bad,
    output logic           done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sd_last;
    logic sd;
    logic clk_prev;
    logic fs_prev;
    int   n;
    int   pulses;
    // Released line shows the inverse of its last level, never a lucky match
    assign sd = sd_oe ? sd_i : ~sd_last;
    always @(posedge core_clk) sd_last <= sd;
    initial begin
        sclk = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge core_clk);
            sclk <= inv_clk;
            if (start) begin
                done <= 1'b0;
                word = '0;
                sync_bad = 1'b0;
                if (ext_mode) begin
                    repeat (8) @(posedge core_clk);
                    word = {word[31:0], sd};
                    for (n = 1; n <= edges; n++) begin
                        repeat (4) @(posedge core_clk);
                        sclk <= ~inv_clk;
                        repeat (4) @(posedge core_clk);
                        sclk <= inv_clk;
                        word = {word[31:0], sd};
                    end
                end else begin
                    n = 0;
                    pulses = 0;
                    clk_prev = line_clk;
                    fs_prev = 1'b0;
                    while (n < 32) begin
                        @(posedge core_clk);
                        if (fs_prev && fsync == inv_sync) begin
                            pulses++;
                            sync_bad |= (n != 16);
                        end
                        fs_prev = (fsync != inv_sync);
                        if (line_clk && !clk_prev) begin
                            word = {word[31:0], sd};
                            n++;
                            sync_bad |= (fsync == inv_sync);
                        end
                        clk_prev = line_clk;
                    end
                    sync_bad |= (pulses != 1);
                end
                done <= 1'b1;
                wait (!start);
            end
        end
    end
endmodule

// ===== verif/asrp_port_bench.sv
// Self-checking bench for the serial result port
module asrp_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    asrp_pkg::asrp_pins_s pins;
    logic        core_clk, arst_n, conv_start, conv_done, busy, irq;
    logic        psel, penable, pwrite, pready, pslverr, err, sclk_line;
    logic        h_start, h_ext, h_sclk, h_bad, h_done;
    logic [5:0]  h_edges;
    logic [32:0] h_word;
    logic [15:0] result_a, result_b;
    logic [15:8] data_pin_o, data_pin_oe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          errors, compares;
    int          err_pulses;

    asrp_port #(.DIV_W(8)) u_dut (.core_clk(core_clk), .arst_n(arst_n),
        .serial_parallel_select(pins.sps), .clock_source_select(pins.cso),
        .clock_edge_invert(pins.inv_clk), .frame_sync_invert(pins.inv_sync),
        .read_mode_or_chain_in(pins.rmc), .chan_order_sel(pins.ab), .cs_n(pins.cs_n),
        .rd_n(pins.rd_n), .sclk_pin_i(sclk_line), .conv_start(conv_start), .conv_done(conv_done),
        .result_a(result_a), .result_b(result_b), .busy(busy), .data_pin_o(data_pin_o),
        .data_pin_oe(data_pin_oe), .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    asrp_host_model u_host (.core_clk(core_clk), .start(h_start), .ext_mode(h_ext),
        .inv_clk(pins.inv_clk), .inv_sync(pins.inv_sync), .edges(h_edges), .sd_i(data_pin_o[8]),
        .sd_oe(data_pin_oe[8]), .line_clk(sclk_line), .fsync(data_pin_o[10]), .sclk(h_sclk),
        .word(h_word), .sync_bad(h_bad), .done(h_done));
    assign sclk_line = data_pin_oe[9] ? data_pin_o[9] : h_sclk;
    // Count read error pulses seen on the pin in slave mode
    always @(posedge core_clk)
        if (pins.sps && pins.cso && data_pin_oe[11] && data_pin_o[11] === 1'b1) err_pulses++;

    always #12.5 core_clk = ~core_clk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic convert(input logic [15:0] a, input logic [15:0] b);
        @(posedge core_clk);
        conv_start <= 1'b1;
        @(posedge core_clk);
        conv_start <= 1'b0;
        result_a <= a;
        result_b <= b;
        repeat (4) @(posedge core_clk);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic host_read(input logic [5:0] n);
        h_edges <= n;
        h_start <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 5000 && h_done !== 1'b1; i++) @(posedge core_clk);
        h_start <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic end_of_test();
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        end_of_test();
    end

    initial begin
        {core_clk, arst_n, conv_start, conv_done, psel, penable, pwrite, h_start, h_ext} = '0;
        {paddr, pwdata, result_a, result_b, h_edges} = '0;
        pins = '0;
        pins.cs_n = 1'b1;
        pins.rd_n = 1'b1;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        apb(1'b0, asrp_pkg::OFS_CTRL, 32'h0);
        check("ctrl reset", {24'h0, asrp_pkg::DIV_RST}, rd);
        apb(1'b0, asrp_pkg::OFS_IRQ_EN, 32'h0);
        check("irq enable reset", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, asrp_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, asrp_pkg::OFS_IRQ_EN, 32'h1);
        pins.cs_n <= 1'b0;
        pins.rd_n <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            pins.ab <= k[0];
            convert(16'ha5c3, 16'h3c5a);
            check("parallel byte", k ? 32'h3c : 32'ha5, {24'h0, data_pin_o});
            check("parallel enable", 32'hff, {24'h0, data_pin_oe});
        end
        pins.cs_n <= 1'b1;
        pins.sps <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            pins.ab <= k[0];
            pins.inv_sync <= k[0];
            pins.rmc <= ~k[0];
            convert(16'hc3a5, 16'h1e69);
            pins.cs_n <= 1'b0;
            host_read(6'd0);
            check("internal word", k ? 32'h1e69c3a5 : 32'hc3a51e69, h_word[31:0]);
            check("frame sync", 32'h0, {31'h0, h_bad});
            check("upper pins off", 32'h0, {28'h0, data_pin_oe[15:12]});
            pins.cs_n <= 1'b1;
        end
        h_ext <= 1'b1;
        pins.cso <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            pins.ab <= k[0];
            pins.inv_clk <= k[0];
            pins.rmc <= ~k[0];
            convert(16'h6b2d, 16'hd4f0);
            pins.cs_n <= 1'b0;
            host_read(6'd32);
            check("external word", k ? 32'hd4f06b2d : 32'h6b2dd4f0, h_word[32:1]);
            check("chain bit", {31'h0, ~k[0]}, {31'h0, h_word[0]});
            pins.cs_n <= 1'b1;
        end
        pins.inv_clk <= 1'b0;
        convert(16'h1234, 16'h5678);
        pins.cs_n <= 1'b0;
        host_read(6'd10);
        convert(16'h9abc, 16'hdef0);
        check("error irq", 32'h1, {31'h0, irq});
        check("error pin pulses", 32'h1, err_pulses);
        apb(1'b0, asrp_pkg::OFS_STATUS, 32'h0);
        check("error status", 32'h1, rd & 32'h1);
        apb(1'b1, asrp_pkg::OFS_IRQ_CLR, 32'h1);
        repeat (2) @(posedge core_clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        pins.cs_n <= 1'b1;
        end_of_test();
    end
endmodule
